/* File: design/srcu_pkg.sv */
// Purpose: Shared constants and types of the serial register command unit
// Assumes: 24-bit frames, opcode in the top five bits
// Notes:   All register resets are zero
package srcu_pkg;

  // Frame layout
  localparam int unsigned FRAME_BITS = 24;
  localparam logic [4:0]  CNT_FULL   = 5'h18;
  localparam logic [4:0]  CNT_SAT    = 5'h1F;
  localparam int unsigned OP_HI      = 23;
  localparam int unsigned OP_LO      = 19;
  localparam int unsigned AD_HI      = 18;
  localparam int unsigned AD_LO      = 8;
  localparam int unsigned DT_HI      = 7;

  // Opcodes
  localparam logic [4:0] idle_command      = 5'h00;
  localparam logic [4:0] write_command     = 5'h01;
  localparam logic [4:0] read_command      = 5'h02;
  localparam logic [4:0] bit_set_command   = 5'h03;
  localparam logic [4:0] bit_clear_command = 5'h04;

  // Register addresses
  localparam logic [10:0] A_UNLOCK = 11'h000;
  localparam logic [10:0] A_PD     = 11'h004;
  localparam logic [10:0] A_INPROT = 11'h008;
  localparam logic [10:0] A_OUTPRO = 11'h00C;
  localparam logic [10:0] A_OUTRAT = 11'h00D;
  localparam logic [10:0] A_OUTRSV = 11'h00E;
  localparam logic [10:0] A_STSPIN = 11'h00F;
  localparam logic [10:0] A_WORD   = 11'h010;
  localparam logic [10:0] A_PARITY = 11'h011;

  // Storage indices
  localparam int unsigned NREG     = 9;
  localparam logic [3:0]  I_UNLOCK = 4'h0;
  localparam logic [3:0]  I_PD     = 4'h1;
  localparam logic [3:0]  I_INPROT = 4'h2;

  // Writable bits per index, reserved bits stay zero
  localparam logic [NREG-1:0][7:0] REG_MASK = {8'hFF, 8'hFF, 8'h01, 8'h00,
                                               8'h01, 8'h77, 8'h03, 8'h1E, 8'hFF};
  localparam logic [7:0] REG_RESET  = 8'h00;
  localparam logic [7:0] UNLOCK_KEY = 8'hAA;

  // Power-down field positions
  localparam int unsigned BIT_HALF_REF = 4;
  localparam int unsigned BIT_CORE     = 1;

  typedef struct packed {
    logic half_ref_buffer_off;
    logic reference_off;
    logic ref_buffer_off;
    logic converter_core_off;
  } srcu_pd_t;

  typedef enum logic [1:0] {
    st_idle  = 2'h1,
    st_frame = 2'h2
  } srcu_state_t;

  typedef struct packed {
    logic f1;
    logic f2;
    logic f3;
    logic lvl;
  } srcu_sync_t;

  typedef struct packed {
    srcu_state_t           st;
    logic [4:0]            cnt;
    logic [FRAME_BITS-1:0] sh;
    logic [1:0]            mode;
    logic [7:0]            osh;
    logic                  sdo;
    logic                  cs_prev;
    logic                  sclk_prev;
    logic [NREG-1:0][7:0]  regs;
    srcu_pd_t              pd;
  } srcu_core_t;

  // Address decode: {hit, index}
  function automatic logic [4:0] addr_to_idx(input logic [10:0] a);
    logic [4:0] r;
    r = 5'h00;
    case (a)
      A_UNLOCK: r = 5'h10;
      A_PD:     r = 5'h11;
      A_INPROT: r = 5'h12;
      A_OUTPRO: r = 5'h13;
      A_OUTRAT: r = 5'h14;
      A_OUTRSV: r = 5'h15;
      A_STSPIN: r = 5'h16;
      A_WORD:   r = 5'h17;
      A_PARITY: r = 5'h18;
      default:  r = 5'h00;
    endcase
    return r;
  endfunction : addr_to_idx

endpackage : srcu_pkg

/* File: design/srcu_pin_sync.sv */
// Purpose: Three-stage synchroniser with agreement filter for one pin
// Assumes: Pin is asynchronous to mclk
// Notes:   Level moves only when stages two and three agree
`timescale 1ns/1ps
module srcu_pin_sync #(
  parameter logic RST_LVL = 1'b0
) (
  // Clock and control
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic ce,
  // Pin and filtered level
  input  wire logic pin,
  output logic      lvl
);

  srcu_pkg::srcu_sync_t q_q;
  srcu_pkg::srcu_sync_t q_d;

  // First stage feeds only the second
  always_comb begin
    q_d     = q_q;
    q_d.f1  = pin;
    q_d.f2  = q_q.f1;
    q_d.f3  = q_q.f2;
    q_d.lvl = (q_q.f2 == q_q.f3) ? q_q.f3 : q_q.lvl;
  end

  // Registered copy
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      q_q <= '{f1: RST_LVL, f2: RST_LVL, f3: RST_LVL, lvl: RST_LVL};
    end else if (ce) begin
      q_q <= q_d;
    end
  end

  assign lvl = q_q.lvl;

endmodule : srcu_pin_sync

/* File: design/srcu_reg_update.sv */
// Purpose: New value of one register under a modify command
// Assumes: Caller gates en with decode and unlock checks
// Notes:   Reserved bits forced to zero by mask
`timescale 1ns/1ps
module srcu_reg_update (
  // Command
  input  wire logic [4:0] op,
  input  wire logic       en,
  // Data
  input  wire logic [7:0] cur,
  input  wire logic [7:0] pay,
  input  wire logic [7:0] mask,
  // Result
  output logic [7:0]      nxt,
  output logic            wr
);

  // Merge payload into current value
  always_comb begin
    nxt = cur;
    wr  = 1'b0;
    case (op)
      srcu_pkg::write_command: begin
        nxt = pay & mask;
        wr  = en;
      end
      srcu_pkg::bit_set_command: begin
        nxt = (cur | pay) & mask;
        wr  = en;
      end
      srcu_pkg::bit_clear_command: begin
        nxt = cur & ~pay & mask;
        wr  = en;
      end
      default: begin
        nxt = cur;
        wr  = 1'b0;
      end
    endcase
  end

endmodule : srcu_reg_update

/* File: design/srcu_core.sv */
// Purpose: Serial command decoder and configuration register file
// Assumes: Serial pins asynchronous, sclk well below mclk/8
// Notes:   Commands act when chip-select rises after 24 clocks
`timescale 1ns/1ps
module srcu_core (
  // Clock, reset, freeze
  input  wire logic           mclk,
  input  wire logic           rst_n,
  input  wire logic           ce,
  // Serial port
  input  wire logic           sclk,
  input  wire logic           cs_n,
  input  wire logic           sdi,
  output logic                sdo,
  // Power-down controls to analog
  output srcu_pkg::srcu_pd_t  pd,
  // Protocol select for the read path
  output logic [1:0]          proto_mode
);

  srcu_pkg::srcu_core_t q_q;
  srcu_pkg::srcu_core_t q_d;

  logic       sclk_lvl;
  logic       cs_lvl;
  logic       sdi_lvl;
  logic       cs_rise;
  logic       cs_fall;
  logic       sclk_r;
  logic       sclk_f;
  logic       cap;
  logic       lnch;
  logic       frame_ok;
  logic       take;
  logic [4:0] op;
  logic [7:0] pay;
  logic [4:0] dec;
  logic       hit;
  logic [3:0] idx;
  logic       wr_ok;
  logic [7:0] rd_val;
  logic [7:0] upd_val;
  logic       upd_wr;

  // Pins cross into mclk; chip-select idles high
  srcu_pin_sync #(.RST_LVL(1'b0)) u_sync_sclk (
    .mclk  (mclk),
    .rst_n (rst_n),
    .ce    (ce),
    .pin   (sclk),
    .lvl   (sclk_lvl)
  );

  srcu_pin_sync #(.RST_LVL(1'b1)) u_sync_cs (
    .mclk  (mclk),
    .rst_n (rst_n),
    .ce    (ce),
    .pin   (cs_n),
    .lvl   (cs_lvl)
  );

  srcu_pin_sync #(.RST_LVL(1'b0)) u_sync_sdi (
    .mclk  (mclk),
    .rst_n (rst_n),
    .ce    (ce),
    .pin   (sdi),
    .lvl   (sdi_lvl)
  );

  // Edges of the filtered pins
  assign cs_rise = ~q_q.cs_prev & cs_lvl;
  assign cs_fall = q_q.cs_prev & ~cs_lvl;
  assign sclk_r  = ~q_q.sclk_prev & sclk_lvl;
  assign sclk_f  = q_q.sclk_prev & ~sclk_lvl;

  // Modes 0 and 3 capture on rising, 1 and 2 on falling
  assign cap  = (q_q.mode[1] == q_q.mode[0]) ? sclk_r : sclk_f;
  assign lnch = (q_q.mode[1] == q_q.mode[0]) ? sclk_f : sclk_r;

  // Short or long frames are dropped whole
  assign frame_ok = (q_q.cnt == srcu_pkg::CNT_FULL);
  assign take     = ce & (q_q.st == srcu_pkg::st_frame) & cs_rise & frame_ok;

  // Field split of the received word
  assign op  = q_q.sh[srcu_pkg::OP_HI:srcu_pkg::OP_LO];
  assign pay = q_q.sh[srcu_pkg::DT_HI:0];
  assign dec = srcu_pkg::addr_to_idx(q_q.sh[srcu_pkg::AD_HI:srcu_pkg::AD_LO]);
  assign hit = dec[4];
  assign idx = dec[3:0];

  // Unlock register itself is always writable
  assign wr_ok = (idx == srcu_pkg::I_UNLOCK) ||
                 (q_q.regs[srcu_pkg::I_UNLOCK] == srcu_pkg::UNLOCK_KEY);

  // Unmapped addresses read as zero
  assign rd_val = hit ? q_q.regs[idx] : 8'h00;

  srcu_reg_update u_update (
    .op   (op),
    .en   (hit & wr_ok),
    .cur  (q_q.regs[idx]),
    .pay  (pay),
    .mask (srcu_pkg::REG_MASK[idx]),
    .nxt  (upd_val),
    .wr   (upd_wr)
  );

  // Next-state of the whole block
  always_comb begin
    q_d           = q_q;
    q_d.cs_prev   = cs_lvl;
    q_d.sclk_prev = sclk_lvl;
    case (q_q.st)
      srcu_pkg::st_idle: begin
        if (cs_fall) begin
          q_d.st   = srcu_pkg::st_frame;
          q_d.cnt  = 5'h00;
          // Protocol sampled only at frame start
          q_d.mode = q_q.regs[srcu_pkg::I_INPROT][1:0];
          // Phase 0 puts the first bit out at the falling chip-select
          if (!q_d.mode[0]) begin
            q_d.sdo = q_q.osh[7];
            q_d.osh = {q_q.osh[6:0], 1'b0};
          end
        end
      end
      srcu_pkg::st_frame: begin
        if (cs_rise) begin
          q_d.st  = srcu_pkg::st_idle;
          q_d.sdo = 1'b0;
          q_d.osh = 8'h00;
          if (frame_ok) begin
            if (upd_wr) begin
              q_d.regs[idx] = upd_val;
            end
            if (op == srcu_pkg::read_command) begin
              q_d.osh = rd_val;
            end
          end
          // Power controls follow the register only at this edge
          q_d.pd = srcu_pkg::srcu_pd_t'(
            q_d.regs[srcu_pkg::I_PD][srcu_pkg::BIT_HALF_REF:srcu_pkg::BIT_CORE]);
        end else begin
          if (cap) begin
            q_d.sh = {q_q.sh[srcu_pkg::FRAME_BITS-2:0], sdi_lvl};
            if (q_q.cnt != srcu_pkg::CNT_SAT) begin
              q_d.cnt = 5'(q_q.cnt + 5'h01);
            end
          end
          if (lnch) begin
            q_d.sdo = q_q.osh[7];
            q_d.osh = {q_q.osh[6:0], 1'b0};
          end
        end
      end
      default: begin
        q_d.st = srcu_pkg::st_idle;
      end
    endcase
  end

  // Registered copy, frozen while ce is low
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      q_q         <= '0;
      q_q.st      <= srcu_pkg::st_idle;
      q_q.cs_prev <= 1'b1;
    end else if (ce) begin
      q_q <= q_d;
    end
  end

  // Outputs come straight from flops
  assign sdo        = q_q.sdo;
  assign pd         = q_q.pd;
  assign proto_mode = q_q.mode;

  // Checks on command effects
  logic [7:0] pay_m;
  logic       is_mod;
  logic       frame_end;
  assign pay_m  = pay & srcu_pkg::REG_MASK[idx];
  assign is_mod = (op == srcu_pkg::write_command) || (op == srcu_pkg::bit_set_command) ||
                  (op == srcu_pkg::bit_clear_command);
  // Any seen chip-select rise closes the frame, whatever its length
  assign frame_end = ce & cs_rise & (q_q.st == srcu_pkg::st_frame);

  nop_keeps_regs_a: assert property (@(posedge mclk) disable iff (!rst_n)
    take && !is_mod |=> $stable(q_q.regs))
    else $error("idle or reserved opcode changed a register");

  write_stores_a: assert property (@(posedge mclk) disable iff (!rst_n)
    take && op == srcu_pkg::write_command && hit && wr_ok
    |=> q_q.regs[$past(idx)] == $past(pay_m))
    else $error("write did not store payload");

  set_bits_a: assert property (@(posedge mclk) disable iff (!rst_n)
    take && op == srcu_pkg::bit_set_command && hit && wr_ok
    |=> ((q_q.regs[$past(idx)] & $past(pay_m)) == $past(pay_m)) &&
        ((q_q.regs[$past(idx)] & ~$past(pay)) == $past(rd_val & ~pay)))
    else $error("bit set wrong");

  clear_bits_a: assert property (@(posedge mclk) disable iff (!rst_n)
    take && op == srcu_pkg::bit_clear_command && hit && wr_ok
    |=> ((q_q.regs[$past(idx)] & $past(pay)) == 8'h00) &&
        ((q_q.regs[$past(idx)] & ~$past(pay)) == $past(rd_val & ~pay)))
    else $error("bit clear wrong");

  locked_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    take && is_mod && hit && !wr_ok |=> $stable(q_q.regs))
    else $error("locked register was modified");

  read_load_a: assert property (@(posedge mclk) disable iff (!rst_n)
    take && op == srcu_pkg::read_command |=> q_q.osh == $past(rd_val))
    else $error("read data not loaded at frame end");

  read_first_bit_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && q_q.st == srcu_pkg::st_idle && cs_fall &&
    !q_q.regs[srcu_pkg::I_INPROT][0] |=> sdo == $past(q_q.osh[7]))
    else $error("first read bit not driven at frame start");

  pd_at_cs_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $changed(q_q.pd) |-> $past(ce && cs_rise && q_q.st == srcu_pkg::st_frame))
    else $error("power control moved outside chip-select rise");

  pd_rsvd_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (q_q.regs[srcu_pkg::I_PD] & ~srcu_pkg::REG_MASK[srcu_pkg::I_PD]) == 8'h00)
    else $error("reserved power bits not zero");

  capture_count_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && q_q.st == srcu_pkg::st_frame && !cs_rise && cap &&
    q_q.cnt != srcu_pkg::CNT_SAT |=> q_q.cnt == 5'($past(q_q.cnt) + 5'h01))
    else $error("bit count did not follow capture edge");

  mode_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    q_q.st == srcu_pkg::st_frame && $past(q_q.st) == srcu_pkg::st_frame
    |-> $stable(q_q.mode))
    else $error("protocol changed inside a frame");

  // Registers and power controls hold inside a frame; the command waits for chip-select to rise
  quiet_in_frame_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && q_q.st == srcu_pkg::st_frame && !cs_rise
    |=> $stable(q_q.regs) && $stable(q_q.pd))
    else $error("register or power control moved inside a frame");

  pd_follows_reg_a: assert property (@(posedge mclk) disable iff (!rst_n)
    frame_end |=> q_q.pd == srcu_pkg::srcu_pd_t'(
      q_q.regs[srcu_pkg::I_PD][srcu_pkg::BIT_HALF_REF:srcu_pkg::BIT_CORE]))
    else $error("power controls differ from the power register");

  // Short and long frames leave the registers alone
  short_frame_drop_a: assert property (@(posedge mclk) disable iff (!rst_n)
    frame_end && !frame_ok
    |=> $stable(q_q.regs))
    else $error("frame of wrong length changed a register");

  // Only a read command leaves data for the next frame
  osh_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
    frame_end && !(frame_ok && op == srcu_pkg::read_command)
    |=> q_q.osh == 8'h00)
    else $error("stale read data left after frame");

  frame_end_sdo_a: assert property (@(posedge mclk) disable iff (!rst_n)
    frame_end |=> sdo == 1'b0)
    else $error("serial output not low after frame");

  // Unmapped places must not leak a mapped register
  unmapped_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    take && op == srcu_pkg::read_command && !hit
    |=> q_q.osh == 8'h00)
    else $error("unmapped read gave nonzero data");

  locked_pd_a: assert property (@(posedge mclk) disable iff (!rst_n)
    take && is_mod && hit && idx == srcu_pkg::I_PD &&
    q_q.regs[srcu_pkg::I_UNLOCK] != srcu_pkg::UNLOCK_KEY
    |=> $stable(q_q.regs[srcu_pkg::I_PD]))
    else $error("power register modified while locked");

  // A protocol write applies from the next frame only
  mode_latch_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && q_q.st == srcu_pkg::st_idle && cs_fall
    |=> q_q.mode == $past(q_q.regs[srcu_pkg::I_INPROT][1:0]))
    else $error("protocol not taken at frame start");

  // Count restarts so a cut frame cannot leak into the next
  frame_start_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && q_q.st == srcu_pkg::st_idle && cs_fall
    |=> q_q.st == srcu_pkg::st_frame && q_q.cnt == 5'h00)
    else $error("frame start did not clear the bit count");

  // Capture edge shifts exactly the filtered data level
  shift_capture_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && q_q.st == srcu_pkg::st_frame && !cs_rise && cap
    |=> q_q.sh[0] == $past(sdi_lvl))
    else $error("captured bit differs from data pin");

  sdo_launch_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ce && q_q.st == srcu_pkg::st_frame && !cs_rise && lnch
    |=> sdo == $past(q_q.osh[7]))
    else $error("launch edge did not move the output bit");

  // Low clock enable must hold every flop of the decoder
  ce_freeze_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !ce |=> $stable(q_q))
    else $error("state moved while clock enable was low");

  // Main scenarios
  write_seen_c: cover property (@(posedge mclk) disable iff (!rst_n)
    take && op == srcu_pkg::write_command && hit && wr_ok);
  read_seen_c: cover property (@(posedge mclk) disable iff (!rst_n)
    take && op == srcu_pkg::read_command);
  set_seen_c: cover property (@(posedge mclk) disable iff (!rst_n)
    take && op == srcu_pkg::bit_set_command && hit && wr_ok);
  core_off_c: cover property (@(posedge mclk) disable iff (!rst_n)
    $rose(q_q.pd.converter_core_off));
  clear_seen_c: cover property (@(posedge mclk) disable iff (!rst_n)
    take && op == srcu_pkg::bit_clear_command && hit && wr_ok);

endmodule : srcu_core

/* File: verification/srcu_host.sv */
// Purpose: Host controller model that drives command frames on the serial pins
// Assumes: Phases of 10 mclk, above what the pin synchronisers need
// Notes:   Polarity and phase follow mode, set by the bench before each frame
`timescale 1ns/1ps
module srcu_host (
  // Pacing clock
  input  wire logic mclk,
  // Serial pins
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo
);
  localparam int PH = 10;
  logic [1:0] mode;

  // Idle pins at time zero
  initial begin
    mode = 2'h0;
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask : wt

  // One frame of nb clocks; the first eight sdo captures are returned
  task automatic frame(input logic [23:0] cmd, input int nb, output logic [7:0] rd);
    int i;
    rd = 8'h00;
    sclk <= mode[1];
    wt(PH);
    cs_n <= 1'b0;
    for (i = 0; i < nb; i++) begin
      if (!mode[0]) sdi <= cmd[23 - (i % 24)];
      wt(PH);
      if (!mode[0] && i < 8) rd[7-i] = sdo;
      sclk <= ~sclk;
      if (mode[0]) sdi <= cmd[23 - (i % 24)];
      wt(PH);
      if (mode[0] && i < 8) rd[7-i] = sdo;
      sclk <= ~sclk;
    end
    wt(PH);
    // Clock stands still; released data shows the inverse, never a stale bit
    cs_n <= 1'b1;
    sdi  <= ~sdi;
    wt(PH);
  endtask : frame
endmodule : srcu_host

/* File: verification/srcu_core_tb.sv */
// Purpose: Self-checking bench of the serial register command unit
// Assumes: Host model paces the pins; model registers kept by address
// Notes:   Reads are checked on the frame that follows them
`timescale 1ns/1ps
module srcu_core_tb;
  localparam int WAKE = 16; // Core wakeup wait, short stand-in value
  logic               mclk;
  logic               rst_n;
  logic               ce;
  logic [7:0]         frz_rd;
  logic               sclk;
  logic               cs_n;
  logic               sdi;
  logic               sdo;
  srcu_pkg::srcu_pd_t pd;
  logic [1:0]         proto_mode;
  int                 error_cnt;
  int                 tests_run;
  int                 mdl [int];
  int                 msk [int];
  int                 rd_pend;
  int                 i;
  logic [31:0]        rv;
  int                 addrs [9] = '{0, 4, 8, 12, 13, 14, 15, 16, 17};
  int                 masks [9] = '{255, 30, 3, 119, 1, 0, 1, 255, 255};

  // Free-running clock
  always #2 mclk = ~mclk;

  srcu_core dut (.mclk(mclk), .rst_n(rst_n), .ce(ce), .sclk(sclk), .cs_n(cs_n),
                 .sdi(sdi), .sdo(sdo), .pd(pd), .proto_mode(proto_mode));
  srcu_host host (.mclk(mclk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("mismatches %0d, comparisons %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  // One frame, model update, then outputs compared once settled
  task automatic cmd(input int op, input int ad, input int dt, input int nb = 24);
    logic [7:0] rd;
    logic [7:0] exp;
    exp = (rd_pend >= 0 && mdl.exists(rd_pend)) ? 8'(mdl[rd_pend]) : 8'h00;
    host.mode = 2'(mdl[8]);
    host.frame({5'(op), 11'(ad), 8'(dt)}, nb, rd);
    if (rd_pend >= 0) chk(rd, exp);
    rd_pend = -1;
    if (nb == 24 && op == 2) rd_pend = ad;
    // Locked writes to protected places are dropped
    if (nb == 24 && op inside {1, 3, 4} && mdl.exists(ad)
        && (ad == 0 || mdl[0] == 8'hAA)) begin
      if (op == 1) mdl[ad] = dt & msk[ad];
      else if (op == 3) mdl[ad] = (mdl[ad] | dt) & msk[ad];
      else mdl[ad] = mdl[ad] & ~dt & msk[ad];
    end
    repeat (8) @(posedge mclk);
    #1;
    chk({4'h0, pd}, 8'((mdl[4] >> 1) & 15));
    chk({6'h0, proto_mode}, {6'h0, host.mode});
  endtask : cmd

  // Hang guard
  initial begin
    repeat (100000) @(posedge mclk);
    error_cnt++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    mclk      = 1'b0;
    rst_n     = 1'b0;
    ce        = 1'b1;
    error_cnt = 0;
    tests_run = 0;
    rd_pend   = -1;
    rv        = $urandom(72);
    for (i = 0; i < 9; i++) begin
      mdl[addrs[i]] = 0;
      msk[addrs[i]] = masks[i];
    end
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (10) @(posedge mclk);
    // Reset values of every register and of an unmapped place
    for (i = 0; i < 9; i++) cmd(2, addrs[i], 0);
    cmd(2, 5, 0);
    cmd(0, 0, 0);
    // Locked after reset
    cmd(1, 4, 'h1E);
    cmd(3, 16, 'hFF);
    cmd(2, 4, 0);
    cmd(2, 16, 0);
    // Wrong key keeps the lock, right key opens it
    cmd(1, 0, 'hAB);
    cmd(1, 16, 'h5A);
    cmd(1, 0, 'hAA);
    cmd(2, 0, 0);
    // Only the full address decodes: an alias of the power register is ignored
    cmd(1, 11'h404, 8'h1E);
    cmd(2, 11'h404, 8'h00);
    // Each power bit alone, then set and clear on top
    for (i = 0; i < 8; i++) cmd(1, 4, 1 << i);
    cmd(1, 4, 'hFF);
    // A frame sent while the clock enable is low is never seen
    ce <= 1'b0;
    host.frame({5'h01, 11'h004, 8'h00}, 24, frz_rd);
    ce <= 1'b1;
    repeat (8) @(posedge mclk);
    chk({4'h0, pd}, 8'((mdl[4] >> 1) & 15));
    cmd(2, 4, 0);
    cmd(4, 4, 'h02);
    repeat (WAKE) @(posedge mclk);
    cmd(3, 4, 'h01);
    // Frames of wrong length change nothing
    cmd(1, 16, 'h33, 23);
    cmd(1, 16, 'h33, 25);
    cmd(2, 16, 0);
    cmd(0, 0, 0);
    // Unassigned opcodes
    for (i = 5; i < 32; i++) cmd(i, 16, $urandom_range(255, 0));
    cmd(2, 16, 0);
    cmd(0, 0, 0);
    // Every protocol, reads carried in each
    for (i = 1; i < 5; i++) begin
      cmd(1, 8, i & 3);
      cmd(2, 16, 0);
      cmd(2, 4, 0);
    end
    // Random traffic over the whole map
    for (i = 0; i < 40; i++)
      cmd($urandom_range(4, 0), addrs[$urandom_range(8, 0)], $urandom_range(255, 0));
    cmd(0, 0, 0);
    // A reset in mid-run brings back the lock, zero registers and mode 0
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    for (i = 0; i < 9; i++) mdl[addrs[i]] = 0;
    rd_pend = -1;
    repeat (10) @(posedge mclk);
    cmd(1, 4, 8'h1E);
    cmd(2, 4, 8'h00);
    cmd(2, 8, 8'h00);
    cmd(0, 0, 0);
    tally_and_finish();
  end
endmodule : srcu_core_tb
